// ---- rcps_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rcps_map.svh"
module rcps_top #(
  parameter int REC_FAST_CYC = `RCPS_REC_FAST_CYC,
  parameter int REC_SLOW_CYC = `RCPS_REC_SLOW_CYC
) (
  input  wire logic        REF_CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic        SLEEP_EXIT_IN,
  input  wire logic        SR_CLK_IN,
  input  wire logic        SR_DATA_IN,
  input  wire logic        SR_LOAD_IN,
  input  wire logic        WRITE_GATE_IN,
  input  wire logic        DETECT_PULSE_IN,
  input  wire logic        RAW_DATA_IN_PIN_IN,
  input  wire logic        FIELD_SELECT_PIN_IN,
  input  wire logic        HOLD_IN,
  input  wire logic [3:0]  SERVO_SWITCH_IN,
  output var  logic        STROBE_DIRECTION_OUT,
  output var  logic [2:0]  STROBE_MAGNITUDE_OUT,
  output var  logic        PUMP_GAIN_SELECT_OUT,
  output var  logic [1:0]  ROUTE_SEL_OUT,
  output var  logic        RAW_DATA_OUT_PIN_OE_OUT,
  output var  logic        RAW_DATA_IN_PIN_EN_OUT,
  output var  logic        RAW_DATA_OUT_PIN_OUT,
  output var  logic        SYNC_DATA_OUT,
  output var  logic        TEST_MODE_OUT,
  output var  logic        SHORT_PREAMBLE_SELECT_OUT,
  output var  logic        WRITE_GATE_POLARITY_OUT,
  output var  logic        AMP_LOW_Z_OUT,
  output var  logic        AGC_FREEZE_OUT,
  output var  logic [2:0]  QUAL_LEVEL_OUT,
  output var  logic [9:0]  QUAL_PERMILLE_OUT,
  output var  logic        HYS_SERVO_REF_OUT,
  output var  logic [2:0]  SERVO_FIELD_FILTER_OUT,
  output var  logic [3:0]  BURST_GATE_OUT,
  output var  logic        BURST_DISCHARGE_OUT,
  output var  logic        BURST_OBSERVE_OUT,
  output var  logic        SERVO_SEEK_OUT
);
  logic [`RCPS_SR_W-1:0] shift_r;
  logic                  sr_clk_d_r;
  logic                  load_d_r;
  logic                  slow_r;
  logic                  wg_active;
  logic [31:0]           rec_cnt_r;
  logic [3:0]            pulse_cnt_r;
  logic                  pulse_d_r;
  rcps_pkg::rcps_amp_e   amp_st_r;
  rcps_cfg_if            cfg ();

  assign cfg.slow_rec  = slow_r;
  assign cfg.qual_code = QUAL_LEVEL_OUT;
  assign cfg.field_sel = FIELD_SELECT_PIN_IN;

  rcps_qual u_qual (
    .clk_in  (REF_CLK_IN),
    .nrst_in (NRST_IN),
    .cfg     (cfg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial load: data shifts in MSB first, the address pair enters last.
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      shift_r    <= '0;
      sr_clk_d_r <= 1'h0;
      load_d_r   <= 1'h0;
    end else begin
      sr_clk_d_r <= SR_CLK_IN;
      load_d_r   <= SR_LOAD_IN;
      if (SR_CLK_IN && !sr_clk_d_r) begin
        shift_r <= {shift_r[`RCPS_SR_W-2:0], SR_DATA_IN};
      end
    end
  end

  wire load_edge = SR_LOAD_IN && !load_d_r;
  wire sel_10 = load_edge && shift_r[`RCPS_ADDR_HI] && !shift_r[`RCPS_ADDR_LO];
  wire sel_11 = load_edge && shift_r[`RCPS_ADDR_HI] && shift_r[`RCPS_ADDR_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Bank 10 upper fields. Sleep exit presets like power-up.
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      STROBE_DIRECTION_OUT <= `RCPS_RST_STR_DIR;
      STROBE_MAGNITUDE_OUT <= `RCPS_RST_STR_MAG;
      PUMP_GAIN_SELECT_OUT <= `RCPS_RST_PUMP;
    end else if (SLEEP_EXIT_IN) begin
      STROBE_DIRECTION_OUT <= `RCPS_RST_STR_DIR;
      STROBE_MAGNITUDE_OUT <= `RCPS_RST_STR_MAG;
      PUMP_GAIN_SELECT_OUT <= `RCPS_RST_PUMP;
    end else if (sel_10) begin
      STROBE_DIRECTION_OUT <= shift_r[`RCPS_STR_DIR_BIT];
      STROBE_MAGNITUDE_OUT <= shift_r[`RCPS_STR_MAG_LSB +: 3];
      PUMP_GAIN_SELECT_OUT <= shift_r[`RCPS_PUMP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank 11.
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ROUTE_SEL_OUT             <= `RCPS_RST_ROUTE;
      SHORT_PREAMBLE_SELECT_OUT <= `RCPS_RST_PREAM;
      WRITE_GATE_POLARITY_OUT   <= `RCPS_RST_WGPOL;
      slow_r                    <= `RCPS_RST_SLOW;
      QUAL_LEVEL_OUT            <= `RCPS_RST_QUAL;
      SERVO_FIELD_FILTER_OUT    <= `RCPS_RST_SFILT;
    end else if (SLEEP_EXIT_IN) begin
      ROUTE_SEL_OUT             <= `RCPS_RST_ROUTE;
      SHORT_PREAMBLE_SELECT_OUT <= `RCPS_RST_PREAM;
      WRITE_GATE_POLARITY_OUT   <= `RCPS_RST_WGPOL;
      slow_r                    <= `RCPS_RST_SLOW;
      QUAL_LEVEL_OUT            <= `RCPS_RST_QUAL;
      SERVO_FIELD_FILTER_OUT    <= `RCPS_RST_SFILT;
    end else if (sel_11) begin
      ROUTE_SEL_OUT             <= shift_r[`RCPS_ROUTE_LSB +: 2];
      SHORT_PREAMBLE_SELECT_OUT <= shift_r[`RCPS_PREAM_BIT];
      WRITE_GATE_POLARITY_OUT   <= shift_r[`RCPS_WGPOL_BIT];
      slow_r                    <= shift_r[`RCPS_SLOW_BIT];
      QUAL_LEVEL_OUT            <= shift_r[`RCPS_QUAL_LSB +: 3];
      SERVO_FIELD_FILTER_OUT    <= shift_r[`RCPS_SFILT_LSB +: 3];
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      QUAL_PERMILLE_OUT <= 10'h0;
      HYS_SERVO_REF_OUT <= 1'h0;
    end else begin
      QUAL_PERMILLE_OUT <= cfg.qual_permille;
      HYS_SERVO_REF_OUT <= cfg.hys_servo_ref;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Detector routing and fixed-width pulse shaping.
  wire ext_in = ROUTE_SEL_OUT[1];
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      pulse_d_r   <= 1'h0;
      pulse_cnt_r <= 4'h0;
    end else begin
      pulse_d_r <= DETECT_PULSE_IN;
      if (DETECT_PULSE_IN && !pulse_d_r) begin
        pulse_cnt_r <= 4'(`RCPS_PULSE_CYC);
      end else if (pulse_cnt_r != 4'h0) begin
        pulse_cnt_r <= pulse_cnt_r - 4'h1;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      RAW_DATA_OUT_PIN_OE_OUT <= 1'h0;
      RAW_DATA_IN_PIN_EN_OUT  <= 1'h0;
      RAW_DATA_OUT_PIN_OUT    <= 1'h0;
      SYNC_DATA_OUT           <= 1'h0;
      TEST_MODE_OUT           <= 1'h0;
    end else begin
      RAW_DATA_OUT_PIN_OE_OUT <= (ROUTE_SEL_OUT != rcps_pkg::RCPS_ROUTE_NONE);
      RAW_DATA_IN_PIN_EN_OUT  <= ext_in;
      RAW_DATA_OUT_PIN_OUT    <= (pulse_cnt_r != 4'h0);
      SYNC_DATA_OUT           <= ext_in ? RAW_DATA_IN_PIN_IN : (pulse_cnt_r != 4'h0);
      // Test mode tells the analog side to fix gain and stop both oscillators.
      TEST_MODE_OUT           <= (ROUTE_SEL_OUT == rcps_pkg::RCPS_ROUTE_TEST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Amplifier input recovery after write.
  assign wg_active = WRITE_GATE_IN ^ WRITE_GATE_POLARITY_OUT;
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      amp_st_r  <= rcps_pkg::RCPS_AMP_READ;
      rec_cnt_r <= 32'h0;
    end else begin
      unique case (amp_st_r)
        rcps_pkg::RCPS_AMP_READ: begin
          if (wg_active) amp_st_r <= rcps_pkg::RCPS_AMP_WRITE;
        end
        rcps_pkg::RCPS_AMP_WRITE: begin
          if (!wg_active) begin
            amp_st_r  <= rcps_pkg::RCPS_AMP_RECOV;
            rec_cnt_r <= cfg.slow_rec ? 32'(REC_FAST_CYC - 1) : 32'(REC_SLOW_CYC - 1);
          end
        end
        rcps_pkg::RCPS_AMP_RECOV: begin
          if (wg_active) amp_st_r <= rcps_pkg::RCPS_AMP_WRITE;
          else if (rec_cnt_r == 32'h0) amp_st_r <= rcps_pkg::RCPS_AMP_READ;
          else rec_cnt_r <= rec_cnt_r - 32'h1;
        end
        default: amp_st_r <= rcps_pkg::RCPS_AMP_READ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      AMP_LOW_Z_OUT  <= 1'h0;
      AGC_FREEZE_OUT <= 1'h0;
    end else begin
      // The write state term bridges the cycle in which the gate drops, so the inputs never glitch high-Z.
      AMP_LOW_Z_OUT  <= wg_active || (amp_st_r == rcps_pkg::RCPS_AMP_WRITE) ||
                        (amp_st_r == rcps_pkg::RCPS_AMP_RECOV && rec_cnt_r != 32'h0);
      AGC_FREEZE_OUT <= wg_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Servo control. Illegal a-and-c with hold low keeps the mode unchanged.
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      SERVO_SEEK_OUT      <= rcps_pkg::RCPS_TRACK;
      BURST_GATE_OUT      <= 4'h0;
      BURST_DISCHARGE_OUT <= 1'h0;
      BURST_OBSERVE_OUT   <= 1'h0;
    end else begin
      if (!HOLD_IN && !(SERVO_SWITCH_IN[0] && SERVO_SWITCH_IN[2])) begin
        if (SERVO_SWITCH_IN[0]) SERVO_SEEK_OUT <= rcps_pkg::RCPS_TRACK;
        else if (SERVO_SWITCH_IN[2]) SERVO_SEEK_OUT <= rcps_pkg::RCPS_SEEK;
      end
      BURST_GATE_OUT      <= HOLD_IN ? SERVO_SWITCH_IN : 4'h0;
      BURST_DISCHARGE_OUT <= !HOLD_IN && SERVO_SWITCH_IN[3];
      BURST_OBSERVE_OUT   <= !HOLD_IN && SERVO_SWITCH_IN[1];
    end
  end
endmodule // rcps_top
`default_nettype wire

// ---- rcps_map.svh ----
`ifndef RCPS_MAP_SVH
`define RCPS_MAP_SVH
`define RCPS_SR_W         13
`define RCPS_ADDR_LO      0
`define RCPS_ADDR_HI      1
`define RCPS_STR_DIR_BIT  8
`define RCPS_STR_MAG_LSB  9
`define RCPS_PUMP_BIT     12
`define RCPS_ROUTE_LSB    2
`define RCPS_PREAM_BIT    4
`define RCPS_WGPOL_BIT    5
`define RCPS_SLOW_BIT     6
`define RCPS_QUAL_LSB     7
`define RCPS_SFILT_LSB    10
`define RCPS_RST_STR_DIR  1'h0
`define RCPS_RST_STR_MAG  3'h0
`define RCPS_RST_PUMP     1'h0
`define RCPS_RST_ROUTE    2'h0
`define RCPS_RST_PREAM    1'h0
`define RCPS_RST_WGPOL    1'h1
`define RCPS_RST_SLOW     1'h1
`define RCPS_RST_QUAL     3'h5
`define RCPS_RST_SFILT    3'h7
`define RCPS_CLK_PS       5000
`define RCPS_REC_FAST_PS  1700000
`define RCPS_REC_SLOW_PS  3400000
`define RCPS_PULSE_PS     15000
`define RCPS_REC_FAST_CYC (`RCPS_REC_FAST_PS / `RCPS_CLK_PS)
`define RCPS_REC_SLOW_CYC (`RCPS_REC_SLOW_PS / `RCPS_CLK_PS)
`define RCPS_PULSE_CYC    ((`RCPS_PULSE_PS + `RCPS_CLK_PS - 1) / `RCPS_CLK_PS)
`define RCPS_QUAL_BASE    605
`define RCPS_QUAL_STEP    45
`endif

// ---- rcps_pkg.sv ----
package rcps_pkg;
  typedef enum logic [1:0] {
    RCPS_ROUTE_NONE = 2'h0,
    RCPS_ROUTE_OUT  = 2'h1,
    RCPS_ROUTE_BOTH = 2'h2,
    RCPS_ROUTE_TEST = 2'h3
  } rcps_route_e;
  typedef enum logic [1:0] {
    RCPS_AMP_READ  = 2'h0,
    RCPS_AMP_WRITE = 2'h1,
    RCPS_AMP_RECOV = 2'h3
  } rcps_amp_e;
  typedef enum logic {
    RCPS_TRACK = 1'h0,
    RCPS_SEEK  = 1'h1
  } rcps_servo_e;
endpackage

// ---- rcps_cfg_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface rcps_cfg_if;
  logic       slow_rec;
  logic [2:0] qual_code;
  logic       field_sel;
  logic [9:0] qual_permille;
  logic       hys_servo_ref;
  modport bank (output slow_rec, output qual_code, output field_sel);
  modport user (input slow_rec, input qual_code, input field_sel, output qual_permille, output hys_servo_ref);
endinterface
`default_nettype wire

// ---- rcps_qual.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rcps_map.svh"
module rcps_qual (
  input  wire logic  clk_in,
  input  wire logic  nrst_in,
  rcps_cfg_if.user   cfg
);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg.qual_permille <= 10'h0;
      cfg.hys_servo_ref <= 1'h0;
    end else begin
      // Level kept in tenths of a percent so the half steps stay exact.
      cfg.qual_permille <= 10'(`RCPS_QUAL_BASE - `RCPS_QUAL_STEP * int'(cfg.qual_code));
      cfg.hys_servo_ref <= cfg.field_sel;
    end
  end
endmodule // rcps_qual
`default_nettype wire

// ---- rcps_props_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module rcps_props (
  input wire logic       REF_CLK_IN,
  input wire logic       NRST_IN,
  input wire logic       DETECT_PULSE_IN,
  input wire logic       WRITE_GATE_IN,
  input wire logic       HOLD_IN,
  input wire logic       FIELD_SELECT_PIN_IN,
  input wire logic [3:0] SERVO_SWITCH_IN,
  input wire logic [1:0] ROUTE_SEL_OUT,
  input wire logic       RAW_DATA_OUT_PIN_OE_OUT,
  input wire logic       TEST_MODE_OUT,
  input wire logic       RAW_DATA_OUT_PIN_OUT,
  input wire logic       WRITE_GATE_POLARITY_OUT,
  input wire logic       AMP_LOW_Z_OUT,
  input wire logic       AGC_FREEZE_OUT,
  input wire logic [2:0] QUAL_LEVEL_OUT,
  input wire logic [9:0] QUAL_PERMILLE_OUT,
  input wire logic       HYS_SERVO_REF_OUT,
  input wire logic [3:0] BURST_GATE_OUT,
  input wire logic       BURST_OBSERVE_OUT,
  input wire logic       SERVO_SEEK_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  ////////////////////////////////////////////////////////////////////////////////
  // Decodes are judged only once the route field has settled, so a one-cycle decode lag is allowed.
  property p_pin_en; $stable(ROUTE_SEL_OUT) |-> RAW_DATA_OUT_PIN_OE_OUT == (ROUTE_SEL_OUT != 2'h0); endproperty
  a_pin_en: assert property (p_pin_en) else $error("pin enable wrong");
  property p_test; $stable(ROUTE_SEL_OUT) |-> TEST_MODE_OUT == (ROUTE_SEL_OUT == 2'h3); endproperty
  a_test: assert property (p_test) else $error("test mode wrong");
  property p_pulse; $rose(DETECT_PULSE_IN) |-> ##[1:2] RAW_DATA_OUT_PIN_OUT [*3] ##1 !RAW_DATA_OUT_PIN_OUT; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse width wrong");
  property p_wg; WRITE_GATE_IN != WRITE_GATE_POLARITY_OUT |=> AMP_LOW_Z_OUT && AGC_FREEZE_OUT; endproperty
  a_wg: assert property (p_wg) else $error("write protection missing");
  property p_obs; 1'h1 |=> BURST_OBSERVE_OUT == (!$past(HOLD_IN) && $past(SERVO_SWITCH_IN[1])); endproperty
  a_obs: assert property (p_obs) else $error("observe mode wrong");
  property p_gate; HOLD_IN |=> BURST_GATE_OUT == $past(SERVO_SWITCH_IN); endproperty
  a_gate: assert property (p_gate) else $error("burst gate wrong");
  property p_seek; !HOLD_IN && SERVO_SWITCH_IN[0] != SERVO_SWITCH_IN[2] |=> SERVO_SEEK_OUT == $past(SERVO_SWITCH_IN[2]); endproperty
  a_seek: assert property (p_seek) else $error("servo mode wrong");
  property p_hys; NRST_IN |-> ##2 HYS_SERVO_REF_OUT == $past(FIELD_SELECT_PIN_IN, 2); endproperty
  a_hys: assert property (p_hys) else $error("reference select wrong");
  property p_qual; NRST_IN |-> ##2 QUAL_PERMILLE_OUT == 10'h25d - 10'h2d * $past(QUAL_LEVEL_OUT, 2); endproperty
  a_qual: assert property (p_qual) else $error("qualification level wrong");
endmodule // rcps_props
`default_nettype wire

// ---- rcps_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module rcps_ctrl (
  input  wire logic       clk_in,
  output var  logic       sr_clk_out,
  output var  logic       sr_data_out,
  output var  logic       sr_load_out,
  output var  logic       hold_out,
  output var  logic [3:0] switch_out
);
  initial begin
    sr_clk_out  = 1'h0;
    sr_data_out = 1'h0;
    sr_load_out = 1'h0;
    hold_out    = 1'h0;
    switch_out  = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Each serial clock phase lasts at least two cycles, so a sampled edge is never missed.
  task automatic send(input logic [12:0] word);
    for (int i = 12; i >= 0; i--) begin
      @(posedge clk_in);
      sr_clk_out  <= 1'h0;
      sr_data_out <= word[i];
      repeat (2) @(posedge clk_in);
      sr_clk_out <= 1'h1;
      @(posedge clk_in);
    end
    @(posedge clk_in);
    sr_clk_out  <= 1'h0;
    sr_data_out <= ~word[0];
    sr_load_out <= 1'h1;
    repeat (2) @(posedge clk_in);
    sr_load_out <= 1'h0;
  endtask
  task automatic servo(input logic hold, input logic [3:0] sw);
    @(posedge clk_in);
    hold_out   <= hold;
    switch_out <= (!hold && sw[0]) ? (sw & 4'hb) : sw;
  endtask
endmodule // rcps_ctrl
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk, nrst, sleep, wg, det, raw_in, fsel, sr_clk, sr_data, sr_load, hold;
  logic [3:0]  sw, gate;
  logic        dir, pump, oe, in_en, raw_out, sync, test, pream, pol, lowz, freeze, hys, obs, disch, seek;
  logic [2:0]  mag, qual, filt;
  logic [1:0]  route;
  logic [9:0]  permille;
  logic        exp_seek;
  logic [6:0]  exp_srv;
  wire  [14:0] fields = {dir, mag, pump, route, pream, pol, qual, filt};
  logic [12:0] wd [7] = '{13'h1b02, 13'h11d7, 13'h1ffd, 13'h0000, 13'h002b, 13'h1fcf, 13'h0002};
  logic [14:0] ex [7] = '{15'h6c6f, 15'h6d9c, 15'h6d9c, 15'h6d9c, 15'h6e40, 15'h6f3f, 15'h033f};
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cnt;
  rcps_ctrl u_ctrl (.clk_in(clk), .sr_clk_out(sr_clk), .sr_data_out(sr_data), .sr_load_out(sr_load),
    .hold_out(hold), .switch_out(sw));
  rcps_top #(.REC_FAST_CYC(4), .REC_SLOW_CYC(8)) dut (.REF_CLK_IN(clk), .NRST_IN(nrst), .SLEEP_EXIT_IN(sleep),
    .SR_CLK_IN(sr_clk), .SR_DATA_IN(sr_data), .SR_LOAD_IN(sr_load), .WRITE_GATE_IN(wg), .DETECT_PULSE_IN(det),
    .RAW_DATA_IN_PIN_IN(raw_in), .FIELD_SELECT_PIN_IN(fsel), .HOLD_IN(hold), .SERVO_SWITCH_IN(sw),
    .STROBE_DIRECTION_OUT(dir), .STROBE_MAGNITUDE_OUT(mag), .PUMP_GAIN_SELECT_OUT(pump), .ROUTE_SEL_OUT(route),
    .RAW_DATA_OUT_PIN_OE_OUT(oe), .RAW_DATA_IN_PIN_EN_OUT(in_en), .RAW_DATA_OUT_PIN_OUT(raw_out),
    .SYNC_DATA_OUT(sync), .TEST_MODE_OUT(test), .SHORT_PREAMBLE_SELECT_OUT(pream), .WRITE_GATE_POLARITY_OUT(pol),
    .AMP_LOW_Z_OUT(lowz), .AGC_FREEZE_OUT(freeze), .QUAL_LEVEL_OUT(qual), .QUAL_PERMILLE_OUT(permille),
    .HYS_SERVO_REF_OUT(hys), .SERVO_FIELD_FILTER_OUT(filt), .BURST_GATE_OUT(gate), .BURST_DISCHARGE_OUT(disch),
    .BURST_OBSERVE_OUT(obs), .SERVO_SEEK_OUT(seek));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // The recovery count tolerates a few cycles of pipeline, yet short and long settings stay apart.
  task automatic wg_test(input logic act, input int rec);
    @(posedge clk);
    wg <= act;
    repeat (4) @(negedge clk);
    check("write hold", {lowz, freeze}, 2'h3);
    @(posedge clk);
    wg  <= ~act;
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (lowz === 1'h1 && cnt < 40);
    check("recovery", cnt >= rec && cnt <= rec + 3, 1'h1);
  endtask
  initial begin
    nrst = 1'h0;
    sleep = 1'h0;
    wg = 1'h1;
    det = 1'h0;
    raw_in = 1'h0;
    fsel = 1'h0;
    exp_seek = 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    @(negedge clk);
    check("reset", fields, 15'h006f);
    for (int i = 0; i < 7; i++) begin
      u_ctrl.send(wd[i]);
      repeat (3) @(negedge clk);
      check("fields", fields, ex[i]);
    end
    check("qual level", permille, 16'h0122);
    wg_test(1'h1, 4);
    @(posedge clk);
    raw_in <= 1'h1;
    det    <= 1'h1;
    cnt = 0;
    repeat (8) begin
      @(negedge clk);
      cnt += raw_out;
    end
    check("pulse width", cnt, 3);
    check("test route", {sync, test, in_en, oe}, 4'hf);
    @(posedge clk);
    raw_in <= 1'h0;
    det    <= 1'h0;
    repeat (3) @(negedge clk);
    check("sync low", sync, 1'h0);
    for (int k = 0; k < 32; k++) begin
      if (k < 16 && k[0] && k[2]) continue;
      u_ctrl.servo(k[4], k[3:0]);
      fsel <= k[0];
      if (!k[4] && k[0]) exp_seek = 1'h0;
      if (!k[4] && k[2]) exp_seek = 1'h1;
      repeat (2) @(negedge clk);
      exp_srv = {k[4] ? 4'(k[3:0]) : 4'h0, !k[4] && k[3], !k[4] && k[1], exp_seek};
      check("servo", {gate, disch, obs, seek}, exp_srv);
    end
    @(posedge clk);
    sleep <= 1'h1;
    repeat (2) @(posedge clk);
    sleep <= 1'h0;
    repeat (2) @(negedge clk);
    check("sleep exit", fields, 15'h006f);
    check("hys ref", hys, 1'h1);
    @(posedge clk);
    det <= 1'h1;
    cnt = 0;
    repeat (8) begin
      @(negedge clk);
      cnt += sync;
    end
    check("internal sync", cnt, 3);
    @(posedge clk);
    det <= 1'h0;
    wg_test(1'h0, 4);
    u_ctrl.send(13'h002b);
    repeat (3) @(negedge clk);
    wg_test(1'h0, 8);
    wrap_up();
  end
  // The whole sequence needs under two thousand cycles, so this limit only trips on a hang.
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
endmodule // testbench
bind rcps_top rcps_props u_props (.REF_CLK_IN, .NRST_IN, .DETECT_PULSE_IN, .WRITE_GATE_IN, .HOLD_IN,
  .FIELD_SELECT_PIN_IN, .SERVO_SWITCH_IN, .ROUTE_SEL_OUT, .RAW_DATA_OUT_PIN_OE_OUT, .TEST_MODE_OUT,
  .RAW_DATA_OUT_PIN_OUT, .WRITE_GATE_POLARITY_OUT, .AMP_LOW_Z_OUT, .AGC_FREEZE_OUT, .QUAL_LEVEL_OUT,
  .QUAL_PERMILLE_OUT, .HYS_SERVO_REF_OUT, .BURST_GATE_OUT, .BURST_OBSERVE_OUT, .SERVO_SEEK_OUT);
`default_nettype wire
